// *** errstate_classifier.sv ***
// Top of the processing_element error state classifier with syndrome field output.
// Assumes the core exception entry logic drives attributes synchronous to CORE_CLK.
module errstate_classifier #(
  parameter int NUM_PEND = 4,
  parameter bit ALLOW_LEGACY = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic ENTRY_VALID,
  input wire errstate_pkg::exc_type_t EXC_TYPE,
  input wire logic SILENT_PROP,
  input wire logic SW_CAN_RESUME,
  input wire logic NEEDS_REPAIR,
  input wire logic CORRECTED,
  input wire logic UNSYNC,
  input wire logic [errstate_pkg::NUM_ELECT-1:0] ELECT,
  input wire logic SEV_VALID,
  input wire logic [errstate_pkg::NUM_ELECT-1:0] SEV_ELECT,
  input wire logic MERGE_EN,
  input wire logic [NUM_PEND-1:0] PEND_SET,
  input wire logic [NUM_PEND-1:0] PEND_SILENT,
  input wire logic [NUM_PEND-1:0] PEND_RESUME,
  input wire logic [NUM_PEND-1:0] PEND_REPAIR,
  input wire logic [NUM_PEND-1:0] PEND_CORR,
  input wire logic [NUM_PEND-1:0] PEND_UNSYNC,
  input wire logic [NUM_PEND-1:0] PEND_LEGACY,
  output logic STATE_VALID,
  output logic [errstate_pkg::NUM_STATES-1:0] STATE_ONEHOT,
  output logic [2:0] AET64,
  output logic [1:0] SET_FIELD,
  output logic [1:0] AET32,
  output logic IDS_BIT,
  output logic SYND_ZERO,
  output logic [NUM_PEND-1:0] PEND_Q,
  output logic [NUM_PEND-1:0] MERGED
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [NUM_PEND-1:0] lowest(input logic [NUM_PEND-1:0] v);
    logic [NUM_PEND-1:0] r;
    r = '0;
    for (int i = NUM_PEND - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic any_of(input logic [NUM_PEND-1:0] v, input logic [NUM_PEND-1:0] m);
    return |(v & m);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  errstate_pkg::seq_state_t seq_q, seq_d;
  errstate_pkg::exc_type_t type_q, type_d;
  logic silent_q, silent_d, resume_q, resume_d, repair_q, repair_d;
  logic corr_q, corr_d, unsync_q, unsync_d, merge_q, merge_d;
  logic [errstate_pkg::NUM_ELECT-1:0] elect_q, elect_d;
  logic [NUM_PEND-1:0] pend_q, pend_d, take_q, take_d, legacy_q, legacy_d;
  logic valid_q, valid_d, ids_q, ids_d, zero_q, zero_d;
  logic [errstate_pkg::NUM_STATES-1:0] onehot_q, onehot_d;
  logic [2:0] aet64_q, aet64_d;
  logic [1:0] set_q, set_d, aet32_q, aet32_d;

  errattr_if attr ();

  errstate_core u_core (
    .a(attr)
  );

  assign attr.silent_prop = silent_q;
  assign attr.sw_can_resume = resume_q;
  assign attr.needs_repair = repair_q;
  assign attr.corrected = corr_q;
  assign attr.unsync = unsync_q;
  assign attr.exc_type = type_q;
  assign attr.elect = elect_q;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [errstate_pkg::NUM_ELECT-1:0] el;
    logic [NUM_PEND-1:0] pick;
    logic serr_now;
    el = '0;
    pick = '0;
    serr_now = 1'b0;
    type_d = type_q;
    silent_d = silent_q;
    resume_d = resume_q;
    repair_d = repair_q;
    corr_d = corr_q;
    unsync_d = unsync_q;
    merge_d = merge_q;
    elect_d = elect_q;
    take_d = take_q;
    legacy_d = legacy_q;
    // New conditions accumulate while pending ones wait
    pend_d = pend_q | PEND_SET;
    case (seq_q)
      errstate_pkg::SEQ_IDLE: begin
        if (ENTRY_VALID) begin
          serr_now = (EXC_TYPE == errstate_pkg::EXC_SERR_64)
            || (EXC_TYPE == errstate_pkg::EXC_SERR_32);
          el = ELECT;
          if (SEV_VALID) begin
            el = el | SEV_ELECT;
          end
          if (!ALLOW_LEGACY) begin
            el[errstate_pkg::ST_UNCATEGORIZED] = 1'b0;
            el[errstate_pkg::ST_IMPDEF] = 1'b0;
          end
          if (serr_now) begin
            pick = MERGE_EN ? pend_q : lowest(pend_q);
          end
          take_d = pick;
          legacy_d = PEND_LEGACY;
          // Combined effect: worst attribute wins across merged set
          type_d = EXC_TYPE;
          silent_d = SILENT_PROP | any_of(PEND_SILENT, pick);
          resume_d = SW_CAN_RESUME & ~any_of(~PEND_RESUME, pick);
          repair_d = NEEDS_REPAIR | any_of(PEND_REPAIR, pick);
          corr_d = CORRECTED & ~any_of(~PEND_CORR, pick);
          unsync_d = UNSYNC | any_of(PEND_UNSYNC, pick);
          merge_d = (pick != lowest(pick));
          elect_d = el;
          pend_d = (pend_q & ~pick) | PEND_SET;
        end
      end
      errstate_pkg::SEQ_DONE: begin
        take_d = '0;
      end
      default: begin
        take_d = take_q;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      type_q <= errstate_pkg::EXC_SYNC_ABORT_64;
      silent_q <= 1'b0;
      resume_q <= 1'b0;
      repair_q <= 1'b0;
      corr_q <= 1'b0;
      unsync_q <= 1'b0;
      merge_q <= 1'b0;
      elect_q <= '0;
      pend_q <= '0;
      take_q <= '0;
      legacy_q <= '0;
    end else begin
      type_q <= type_d;
      silent_q <= silent_d;
      resume_q <= resume_d;
      repair_q <= repair_d;
      corr_q <= corr_d;
      unsync_q <= unsync_d;
      merge_q <= merge_d;
      elect_q <= elect_d;
      pend_q <= pend_d;
      take_q <= take_d;
      legacy_q <= legacy_d;
    end
  end

  // ************************************************************
  // Entry sequencer
  // ************************************************************
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      errstate_pkg::SEQ_IDLE: begin
        if (ENTRY_VALID) begin
          seq_d = errstate_pkg::SEQ_EVAL;
        end
      end
      errstate_pkg::SEQ_EVAL: begin
        seq_d = errstate_pkg::SEQ_DONE;
      end
      errstate_pkg::SEQ_DONE: begin
        seq_d = errstate_pkg::SEQ_IDLE;
      end
      default: begin
        seq_d = errstate_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      seq_q <= errstate_pkg::SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // ************************************************************
  // Syndrome fields
  // ************************************************************
  logic legacy_merge;

  assign legacy_merge = merge_q && (type_q == errstate_pkg::EXC_SERR_64)
    && any_of(legacy_q, take_q);

  always_comb begin
    logic [errstate_pkg::NUM_STATES-1:0] st;
    st = attr.state;
    valid_d = 1'b0;
    onehot_d = onehot_q;
    aet64_d = aet64_q;
    set_d = set_q;
    aet32_d = aet32_q;
    ids_d = ids_q;
    zero_d = zero_q;
    if (seq_q == errstate_pkg::SEQ_EVAL) begin
      if (legacy_merge) begin
        st = '0;
        st[errstate_pkg::ST_IMPDEF] = 1'b1;
      end
      onehot_d = st;
      valid_d = 1'b1;
      ids_d = errstate_pkg::IDS_CLEAR;
      zero_d = 1'b0;
      aet64_d = errstate_pkg::AET64_UNCONTAINABLE;
      set_d = errstate_pkg::SET_UNCONTAINABLE;
      aet32_d = errstate_pkg::AET32_UNCONTAINABLE;
      if (st[errstate_pkg::ST_IMPDEF]) begin
        ids_d = errstate_pkg::IDS_SET;
      end else if (st[errstate_pkg::ST_UNCATEGORIZED]) begin
        zero_d = 1'b1;
      end else if (st[errstate_pkg::ST_UNRECOVERABLE]) begin
        aet64_d = errstate_pkg::AET64_UNRECOVERABLE;
        aet32_d = errstate_pkg::AET32_UNRECOVERABLE;
      end else if (st[errstate_pkg::ST_RECOVERABLE]) begin
        aet64_d = errstate_pkg::AET64_RECOVERABLE;
        set_d = errstate_pkg::SET_RECOVERABLE;
        aet32_d = errstate_pkg::AET32_RECOVERABLE;
      end else if (st[errstate_pkg::ST_RESTARTABLE]) begin
        aet64_d = errstate_pkg::AET64_RESTARTABLE;
        set_d = errstate_pkg::SET_RESTARTABLE;
        aet32_d = errstate_pkg::AET32_RESTARTABLE;
      end else if (st[errstate_pkg::ST_CORRECTED]) begin
        aet64_d = errstate_pkg::AET64_CORRECTED;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      valid_q <= 1'b0;
      onehot_q <= errstate_pkg::STATE_RESET;
      aet64_q <= errstate_pkg::AET64_UNCONTAINABLE;
      set_q <= errstate_pkg::SET_UNCONTAINABLE;
      aet32_q <= errstate_pkg::AET32_UNCONTAINABLE;
      ids_q <= errstate_pkg::IDS_CLEAR;
      zero_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      onehot_q <= onehot_d;
      aet64_q <= aet64_d;
      set_q <= set_d;
      aet32_q <= aet32_d;
      ids_q <= ids_d;
      zero_q <= zero_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign STATE_VALID = valid_q;
  assign STATE_ONEHOT = onehot_q;
  assign AET64 = aet64_q;
  assign SET_FIELD = set_q;
  assign AET32 = aet32_q;
  assign IDS_BIT = ids_q;
  assign SYND_ZERO = zero_q;
  assign PEND_Q = pend_q;
  assign MERGED = take_q;

endmodule

// *** errstate_pkg.sv ***
// Package of encodings, states and field layouts for the error state classifier.
// Assumes a single core clock domain; included first in compile order.
package errstate_pkg;

  // ************************************************************
  // Exception types
  // ************************************************************
  typedef enum logic [1:0] {
    EXC_SYNC_ABORT_64,
    EXC_SERR_64,
    EXC_SYNC_ABORT_32,
    EXC_SERR_32
  } exc_type_t;

  // ************************************************************
  // One-hot error state positions
  // ************************************************************
  localparam int ST_UNCONTAINABLE = 0;
  localparam int ST_UNRECOVERABLE = 1;
  localparam int ST_RECOVERABLE = 2;
  localparam int ST_RESTARTABLE = 3;
  localparam int ST_CORRECTED = 4;
  localparam int ST_UNCATEGORIZED = 5;
  localparam int ST_IMPDEF = 6;
  localparam int ST_NONE = 7;
  localparam int NUM_STATES = 8;
  localparam logic [7:0] STATE_RESET = 8'h00;

  // ************************************************************
  // Election bit positions (same order as states)
  // ************************************************************
  localparam int NUM_ELECT = 7;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [2:0] AET64_UNCONTAINABLE = 3'h0;
  localparam logic [2:0] AET64_UNRECOVERABLE = 3'h1;
  localparam logic [2:0] AET64_RESTARTABLE = 3'h2;
  localparam logic [2:0] AET64_RECOVERABLE = 3'h3;
  localparam logic [2:0] AET64_CORRECTED = 3'h6;
  localparam logic [1:0] SET_UNCONTAINABLE = 2'h2;
  localparam logic [1:0] SET_RECOVERABLE = 2'h0;
  localparam logic [1:0] SET_RESTARTABLE = 2'h3;
  localparam logic [1:0] AET32_UNCONTAINABLE = 2'h0;
  localparam logic [1:0] AET32_UNRECOVERABLE = 2'h1;
  localparam logic [1:0] AET32_RESTARTABLE = 2'h2;
  localparam logic [1:0] AET32_RECOVERABLE = 2'h3;
  localparam logic IDS_SET = 1'h1;
  localparam logic IDS_CLEAR = 1'h0;

  // ************************************************************
  // Entry sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_EVAL,
    SEQ_DONE
  } seq_state_t;

endpackage

// *** errattr_if.sv ***
// Interface carrying one set of registered error attributes to the classifier core.
// Assumes the attributes are stable while the core evaluates them.
interface errattr_if;
  logic silent_prop;
  logic sw_can_resume;
  logic needs_repair;
  logic corrected;
  logic unsync;
  errstate_pkg::exc_type_t exc_type;
  logic [errstate_pkg::NUM_ELECT-1:0] elect;
  logic [errstate_pkg::NUM_STATES-1:0] state;

  modport src (output silent_prop, sw_can_resume, needs_repair, corrected, unsync,
    exc_type, elect, input state);
  modport core (input silent_prop, sw_can_resume, needs_repair, corrected, unsync,
    exc_type, elect, output state);
endinterface

// *** errstate_core.sv ***
// Combinational error state selection for one error condition.
// Assumes inputs come from registers in the instantiating module.
module errstate_core (
  errattr_if.core a
);

  // ************************************************************
  // Selection
  // ************************************************************
  logic sea32;
  logic serr64;
  logic serr;
  logic [errstate_pkg::NUM_STATES-1:0] st;
  logic [errstate_pkg::NUM_ELECT-1:0] e;

  always_comb begin
    e = a.elect;
    sea32 = (a.exc_type == errstate_pkg::EXC_SYNC_ABORT_32);
    serr64 = (a.exc_type == errstate_pkg::EXC_SERR_64);
    serr = serr64 || (a.exc_type == errstate_pkg::EXC_SERR_32);
    st = '0;
    // Elections of legacy states only count on the 64-bit interrupt
    if (serr64 && e[errstate_pkg::ST_IMPDEF]) begin
      st[errstate_pkg::ST_IMPDEF] = 1'b1;
    end else if (serr64 && e[errstate_pkg::ST_UNCATEGORIZED]) begin
      st[errstate_pkg::ST_UNCATEGORIZED] = 1'b1;
    end else if (!sea32 && (a.silent_prop || e[errstate_pkg::ST_UNCONTAINABLE]
        || (!a.sw_can_resume && a.unsync)
        || (!a.sw_can_resume && a.exc_type == errstate_pkg::EXC_SYNC_ABORT_64))) begin
      st[errstate_pkg::ST_UNCONTAINABLE] = 1'b1;
    end else if (!a.silent_prop && serr && ((!a.sw_can_resume && !a.unsync)
        || e[errstate_pkg::ST_UNRECOVERABLE])) begin
      st[errstate_pkg::ST_UNRECOVERABLE] = 1'b1;
    end else if (!a.silent_prop && !sea32 && a.sw_can_resume
        && (a.needs_repair || e[errstate_pkg::ST_RECOVERABLE])) begin
      st[errstate_pkg::ST_RECOVERABLE] = 1'b1;
    end else if (!a.silent_prop && !sea32 && a.sw_can_resume && !a.needs_repair
        && (!a.corrected || !serr64 || e[errstate_pkg::ST_RESTARTABLE])) begin
      st[errstate_pkg::ST_RESTARTABLE] = 1'b1;
    end else if (a.corrected && !a.silent_prop && serr64 && a.sw_can_resume) begin
      st[errstate_pkg::ST_CORRECTED] = 1'b1;
    end else if (sea32) begin
      st[errstate_pkg::ST_NONE] = 1'b1;
    end else begin
      st[errstate_pkg::ST_UNCONTAINABLE] = 1'b1;
    end
    a.state = st;
  end

endmodule

// *** errstate_classifier_monitor.sv ***
// Checker of the error state classifier, watching only its top-level ports.
// Assumes entries at least three cycles apart; bound into every classifier.
module errstate_classifier_monitor #(
  parameter int NUM_PEND = 4
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic ENTRY_VALID,
  input wire errstate_pkg::exc_type_t EXC_TYPE,
  input wire logic SILENT_PROP,
  input wire logic [NUM_PEND-1:0] PEND_SET,
  input wire logic STATE_VALID,
  input wire logic [errstate_pkg::NUM_STATES-1:0] STATE_ONEHOT,
  input wire logic [2:0] AET64,
  input wire logic [1:0] SET_FIELD,
  input wire logic IDS_BIT,
  input wire logic SYND_ZERO,
  input wire logic [NUM_PEND-1:0] PEND_Q,
  input wire logic [NUM_PEND-1:0] MERGED
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Sequences and assertions
  // ************************************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_take;
    ENTRY_VALID;
  endsequence
  sequence s_answer;
    ##2 STATE_VALID;
  endsequence
  sequence s_pick;
    $rose(|MERGED) && $past(ENTRY_VALID);
  endsequence
  AST_ANSWER_TWO_CYCLES: assert property (s_take |-> s_answer)
    else $error("no result two cycles after entry");
  AST_ONE_HOT: assert property (STATE_VALID |-> $onehot(STATE_ONEHOT))
    else $error("result state not one-hot");
  AST_RESULT_PULSE: assert property (STATE_VALID |=> !STATE_VALID)
    else $error("result strobe too long");
  AST_SYNC32_NONE: assert property (
    ENTRY_VALID && EXC_TYPE == errstate_pkg::EXC_SYNC_ABORT_32
    |-> ##2 STATE_ONEHOT[errstate_pkg::ST_NONE])
    else $error("sync abort 32 gave a state");
  AST_SILENT_UNCONT: assert property (
    ENTRY_VALID && SILENT_PROP && EXC_TYPE == errstate_pkg::EXC_SYNC_ABORT_64
    |-> ##2 STATE_ONEHOT[errstate_pkg::ST_UNCONTAINABLE]
    && SET_FIELD == errstate_pkg::SET_UNCONTAINABLE)
    else $error("propagated error not uncontainable");
  AST_UNCAT_ZERO: assert property (
    STATE_VALID && STATE_ONEHOT[errstate_pkg::ST_UNCATEGORIZED]
    |-> SYND_ZERO && $past(EXC_TYPE, 2) == errstate_pkg::EXC_SERR_64)
    else $error("bad uncategorized");
  AST_IMPDEF_BIT: assert property (
    STATE_VALID && STATE_ONEHOT[errstate_pkg::ST_IMPDEF]
    |-> IDS_BIT && $past(EXC_TYPE, 2) == errstate_pkg::EXC_SERR_64)
    else $error("bad impdef syndrome");
  AST_CORR_CODE: assert property (
    STATE_VALID && STATE_ONEHOT[errstate_pkg::ST_CORRECTED]
    |-> AET64 == errstate_pkg::AET64_CORRECTED) else $error("bad corrected code");
  AST_PICK_PENDING: assert property (s_pick |-> ((MERGED & PEND_Q & ~$past(PEND_SET))
    | ($past(PEND_Q) & ~MERGED & ~PEND_Q)) == '0) else $error("pending set wrong after pick");
  AST_MERGED_WINDOW: assert property (s_pick |=> $stable(MERGED) ##1 MERGED == '0)
    else $error("merged mask window wrong");
endmodule

bind errstate_classifier errstate_classifier_monitor #(.NUM_PEND(NUM_PEND)) u_monitor (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ENTRY_VALID(ENTRY_VALID), .EXC_TYPE(EXC_TYPE),
  .SILENT_PROP(SILENT_PROP), .PEND_SET(PEND_SET), .STATE_VALID(STATE_VALID),
  .STATE_ONEHOT(STATE_ONEHOT), .AET64(AET64), .SET_FIELD(SET_FIELD), .IDS_BIT(IDS_BIT),
  .SYND_ZERO(SYND_ZERO), .PEND_Q(PEND_Q), .MERGED(MERGED)
);

// *** errstate_syndrome_model.sv ***
// Far-side model: the syndrome register recording each classified result.
// Assumes one-cycle result strobes with the fields settled beside them.
module errstate_syndrome_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic state_valid,
  input wire logic [16:0] result,
  output logic [16:0] syn_q,
  output logic [7:0] count_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] syn_d;
  logic [7:0] count_d;
  // ************************************************************
  // Syndrome capture
  // ************************************************************
  always_comb begin
    syn_d = syn_q;
    count_d = count_q;
    if (state_valid) begin
      syn_d = result;
      count_d = count_q + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      syn_q <= 17'h00000;
      count_q <= 8'h00;
    end else begin
      syn_q <= syn_d;
      count_q <= count_d;
    end
  end
endmodule

// *** errstate_classifier_bench.sv ***
// Testbench of the error state classifier: a table of entries with expected states.
// Assumes package, interface, design, checker and syndrome model compiled first.
module errstate_classifier_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ev = 1'b0;
  errstate_pkg::exc_type_t exc = errstate_pkg::EXC_SYNC_ABORT_64;
  logic [4:0] attr = 5'h00;
  logic [6:0] elect = 7'h00;
  logic sev_v = 1'b0;
  logic [6:0] sev_e = 7'h00;
  logic merge = 1'b0;
  logic [3:0] pset = 4'h0;
  logic [3:0] psil = 4'h0;
  logic [3:0] pleg = 4'h0;
  logic [3:0] prsm = 4'hF;
  logic [3:0] punsync = 4'h0;
  logic sv, impdef_syndrome_bit, zero;
  logic [7:0] onehot, cnt;
  logic [2:0] aet64;
  logic [1:0] setf, aet32;
  logic [3:0] pend_q, merged;
  logic [16:0] syn;
  int err_count = 0;
  int checks_done = 0;
  logic [2:0] c64 [0:4] = '{errstate_pkg::AET64_UNCONTAINABLE, errstate_pkg::AET64_UNRECOVERABLE,
    errstate_pkg::AET64_RECOVERABLE, errstate_pkg::AET64_RESTARTABLE, errstate_pkg::AET64_CORRECTED};
  logic [1:0] cset [0:3] = '{errstate_pkg::SET_UNCONTAINABLE, 2'h0, errstate_pkg::SET_RECOVERABLE,
    errstate_pkg::SET_RESTARTABLE};
  logic [1:0] c32 [0:3] = '{errstate_pkg::AET32_UNCONTAINABLE, errstate_pkg::AET32_UNRECOVERABLE,
    errstate_pkg::AET32_RECOVERABLE, errstate_pkg::AET32_RESTARTABLE};

  always #50 clk = ~clk;

  errstate_classifier #(.NUM_PEND(4), .ALLOW_LEGACY(1'b1)) DUT (
    .CORE_CLK(clk), .SYS_RST(rst), .ENTRY_VALID(ev), .EXC_TYPE(exc), .SILENT_PROP(attr[4]),
    .SW_CAN_RESUME(attr[3]), .NEEDS_REPAIR(attr[2]), .CORRECTED(attr[1]), .UNSYNC(attr[0]),
    .ELECT(elect), .SEV_VALID(sev_v), .SEV_ELECT(sev_e), .MERGE_EN(merge), .PEND_SET(pset),
    .PEND_SILENT(psil), .PEND_RESUME(prsm), .PEND_REPAIR(4'h0), .PEND_CORR(4'h0),
    .PEND_UNSYNC(punsync), .PEND_LEGACY(pleg), .STATE_VALID(sv), .STATE_ONEHOT(onehot),
    .AET64(aet64), .SET_FIELD(setf), .AET32(aet32), .IDS_BIT(impdef_syndrome_bit), .SYND_ZERO(zero),
    .PEND_Q(pend_q), .MERGED(merged));
  errstate_syndrome_model partner (.clk(clk), .rst(rst), .state_valid(sv),
    .result({onehot, aet64, setf, aet32, impdef_syndrome_bit, zero}), .syn_q(syn), .count_q(cnt));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic pend(input logic m, input logic [3:0] sil, input logic [3:0] leg,
      input logic [3:0] s);
    @(posedge clk);
    merge <= m;
    psil <= sil;
    pleg <= leg;
    pset <= s;
    @(posedge clk);
    pset <= 4'h0;
  endtask
  task automatic run(input logic [1:0] t, input logic [4:0] a, input logic [6:0] e,
      input logic [2:0] st, input logic [3:0] mrg);
    errstate_pkg::exc_type_t ty;
    logic [7:0] c0;
    int i;
    ty = errstate_pkg::exc_type_t'(t);
    c0 = cnt;
    @(posedge clk);
    ev <= 1'b1;
    exc <= ty;
    attr <= a;
    elect <= e;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    chk(merged, mrg);
    for (i = 0; i < 4 && cnt == c0; i++) begin
      @(posedge clk);
      #1;
    end
    if (cnt == c0) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, cnt, c0 + 8'h01);
      results();
    end
    chk(syn[16:9], 8'h01 << st);
    if (ty == errstate_pkg::EXC_SERR_64 && st == 3'h6) chk(syn[1], 1'b1);
    else if (ty == errstate_pkg::EXC_SERR_64 && st == 3'h5) chk(syn[0], 1'b1);
    else if (ty == errstate_pkg::EXC_SERR_64) chk(syn[8:6], c64[st]);
    else if (ty == errstate_pkg::EXC_SYNC_ABORT_64) chk(syn[5:4], cset[st[1:0]]);
    else if (ty == errstate_pkg::EXC_SERR_32) chk(syn[3:2], c32[st[1:0]]);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(onehot, 8'h00);
    chk(setf, errstate_pkg::SET_UNCONTAINABLE);
    run(2'h0, 5'h10, 7'h00, 3'h0, 4'h0);
    run(2'h1, 5'h0C, 7'h00, 3'h2, 4'h0);
    run(2'h1, 5'h08, 7'h00, 3'h3, 4'h0);
    run(2'h1, 5'h0A, 7'h00, 3'h4, 4'h0);
    run(2'h0, 5'h0A, 7'h00, 3'h3, 4'h0);
    run(2'h1, 5'h0A, 7'h08, 3'h3, 4'h0);
    run(2'h1, 5'h08, 7'h04, 3'h2, 4'h0);
    run(2'h1, 5'h0C, 7'h02, 3'h1, 4'h0);
    run(2'h1, 5'h00, 7'h00, 3'h1, 4'h0);
    run(2'h1, 5'h01, 7'h00, 3'h0, 4'h0);
    run(2'h0, 5'h00, 7'h00, 3'h0, 4'h0);
    run(2'h1, 5'h08, 7'h20, 3'h5, 4'h0);
    run(2'h1, 5'h08, 7'h40, 3'h6, 4'h0);
    run(2'h3, 5'h00, 7'h20, 3'h1, 4'h0);
    run(2'h2, 5'h10, 7'h00, 3'h7, 4'h0);
    run(2'h1, 5'h0A, 7'h01, 3'h0, 4'h0);
    run(2'h3, 5'h0C, 7'h00, 3'h2, 4'h0);
    run(2'h0, 5'h0C, 7'h00, 3'h2, 4'h0);
    run(2'h1, 5'h10, 7'h08, 3'h0, 4'h0);
    run(2'h3, 5'h0A, 7'h00, 3'h3, 4'h0);
    @(posedge clk);
    sev_v <= 1'b1;
    sev_e <= 7'h04;
    run(2'h1, 5'h08, 7'h00, 3'h2, 4'h0);
    @(posedge clk);
    sev_v <= 1'b0;
    pend(1'b1, 4'h2, 4'h0, 4'h3);
    run(2'h0, 5'h08, 7'h00, 3'h3, 4'h0);
    chk(pend_q, 4'h3);
    run(2'h1, 5'h08, 7'h00, 3'h0, 4'h3);
    chk(pend_q, 4'h0);
    pend(1'b1, 4'h0, 4'h0, 4'h1);
    run(2'h1, 5'h0A, 7'h00, 3'h3, 4'h1);
    pend(1'b0, 4'h0, 4'h0, 4'h6);
    run(2'h1, 5'h08, 7'h00, 3'h3, 4'h2);
    chk(pend_q, 4'h4);
    run(2'h3, 5'h08, 7'h00, 3'h3, 4'h4);
    pend(1'b1, 4'h0, 4'h1, 4'h3);
    run(2'h1, 5'h08, 7'h00, 3'h6, 4'h3);
    pend(1'b0, 4'h0, 4'h0, 4'h5);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pend_q, 4'h0);
    run(2'h1, 5'h0C, 7'h00, 3'h2, 4'h0);
    @(posedge clk);
    prsm <= 4'hE;
    punsync <= 4'h2;
    pend(1'b1, 4'h0, 4'h0, 4'h1);
    run(2'h1, 5'h0C, 7'h00, 3'h1, 4'h1);
    pend(1'b1, 4'h0, 4'h0, 4'h3);
    run(2'h1, 5'h0C, 7'h00, 3'h0, 4'h3);
    results();
  end
endmodule
